// ==== include/periph_irq_pkg.sv ====
/*
 * Package for the peripheral interrupt flag and enable register block:
 * register offsets, field layouts, reset values, bus carrier and state.
 * Assumes a classic Wishbone master with 32-bit data and byte addresses.
 */
`default_nettype none

package periph_irq_pkg;

   localparam int WB_ADR_W = 8;
   localparam int WB_DAT_W = 32;
   localparam int WB_SEL_W = 4;
   localparam int REG_W    = 8;
   localparam int F9_W     = 4;
   localparam int F10_W    = 2;

   // Word-aligned byte offsets of the five registers
   localparam logic [WB_ADR_W-1:0] OFF_FLAGS_9   = 8'h00;
   localparam logic [WB_ADR_W-1:0] OFF_FLAGS_10  = 8'h04;
   localparam logic [WB_ADR_W-1:0] OFF_ENABLES_0 = 8'h08;
   localparam logic [WB_ADR_W-1:0] OFF_ENABLES_1 = 8'h0c;
   localparam logic [WB_ADR_W-1:0] OFF_ENABLES_2 = 8'h10;

   // Implemented bits; everything else reads as zero
   localparam logic [REG_W-1:0] FLAGS_9_MASK  = 8'h0f;
   localparam logic [REG_W-1:0] FLAGS_10_MASK = 8'h03;
   localparam logic [REG_W-1:0] REG_RESET     = 8'h00;
   localparam logic [WB_DAT_W-1:0] DAT_ZERO   = 32'h0000_0000;

   typedef struct packed {
      logic [3:0] unused9;
      logic       logic_cell3_flag, waveform_gen3_flag, capcomp3_flag, timer6_flag;
   } flags9_s;

   typedef struct packed {
      logic [5:0] unused10;
      logic       logic_cell4_flag, capcomp4_flag;
   } flags10_s;

   typedef struct packed {
      logic pin_change_enable, crc_done_enable, mem_scanner_enable, nonvolatile_op_enable;
      logic clock_switch_enable, osc_fail_enable, voltage_detect_enable, soft_irq_enable;
   } enables0_s;

   typedef struct packed {
      logic meas_timer_pulse_width_enable, meas_timer_period_enable, meas_timer_enable;
      logic comparator1_enable, adc_threshold_enable, adc_done_enable;
      logic zero_cross_enable, ext_irq0_enable;
   } enables1_s;

   typedef struct packed {
      logic i2c_one_rx_enable, spi_one_enable, spi_one_tx_enable, spi_one_rx_enable;
      logic dma_one_abort_enable, dma_one_overrun_enable;
      logic dma_one_dest_count_enable, dma_one_src_count_enable;
   } enables2_s;

   typedef struct packed {
      logic                cyc;
      logic                stb;
      logic                we;
      logic [WB_ADR_W-1:0] adr;
      logic [WB_SEL_W-1:0] sel;
      logic [WB_DAT_W-1:0] dat;
   } wb_req_s;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_e;

   typedef struct packed {
      bus_state_e          bus;
      logic [WB_DAT_W-1:0] rdata;
      flags9_s             flags9;
      flags10_s            flags10;
      enables0_s           en0;
      enables1_s           en1;
      enables2_s           en2;
      logic [F9_W-1:0]     req9;
      logic [F10_W-1:0]    req10;
      logic [REG_W-1:0]    req0;
      logic [REG_W-1:0]    req1;
      logic [REG_W-1:0]    req2;
   } state_s;

endpackage

`default_nettype wire

// ==== rtl/peripheral_irq_flag_enable_regs.sv ====
/*
 * Peripheral interrupt flag registers 9 and 10 and enable registers 0..2,
 * reached over a classic Wishbone slave, with per-source request outputs.
 * Assumes event sources, external flags and external enables come from
 * logic on mclk; the vectored controller consumes the request outputs.
 */
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module peripheral_irq_flag_enable_regs
   import periph_irq_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                resetn,
   input  wire wb_req_s             wbReq,
   output var  logic                wbAck,
   output var  logic [WB_DAT_W-1:0] wbDatOut,
   input  wire logic [F9_W-1:0]     flags9Event,
   input  wire logic [F10_W-1:0]    flags10Event,
   input  wire logic [F9_W-1:0]     flags9Enable,
   input  wire logic [F10_W-1:0]    flags10Enable,
   input  wire logic [REG_W-1:0]    en0Flags,
   input  wire logic [REG_W-1:0]    en1Flags,
   input  wire logic [REG_W-1:0]    en2Flags,
   output var  logic [F9_W-1:0]     flags9Req,
   output var  logic [F10_W-1:0]    flags10Req,
   output var  logic [REG_W-1:0]    en0Req,
   output var  logic [REG_W-1:0]    en1Req,
   output var  logic [REG_W-1:0]    en2Req
);

   state_s               st_r;
   state_s               st_nxt;
   logic                 busHit;
   logic                 wrNow;
   logic [WB_ADR_W-3:0]  wordAdr;
   logic [WB_DAT_W-1:0]  readMux;
   logic [REG_W-1:0]     f9Write;
   logic [REG_W-1:0]     f10Write;
   logic                 wrFlags9;
   logic                 wrFlags10;
   logic                 wrEn0;
   logic                 wrEn1;
   logic                 wrEn2;
   logic                 mapHit;

   assign busHit  = wbReq.cyc & wbReq.stb;
   assign wordAdr = wbReq.adr[WB_ADR_W-1:2];
   // Writes land on the edge where the master sees ack, as classic cycles expect
   assign wrNow   = busHit & wbReq.we & wbReq.sel[0] & (st_r.bus == BUS_ACK);

   // Per-register write strobes and map decode, read only by the checks below
   assign wrFlags9  = wrNow && (wordAdr == OFF_FLAGS_9[WB_ADR_W-1:2]);
   assign wrFlags10 = wrNow && (wordAdr == OFF_FLAGS_10[WB_ADR_W-1:2]);
   assign wrEn0     = wrNow && (wordAdr == OFF_ENABLES_0[WB_ADR_W-1:2]);
   assign wrEn1     = wrNow && (wordAdr == OFF_ENABLES_1[WB_ADR_W-1:2]);
   assign wrEn2     = wrNow && (wordAdr == OFF_ENABLES_2[WB_ADR_W-1:2]);
   assign mapHit    = (wordAdr == OFF_FLAGS_9[WB_ADR_W-1:2]) || (wordAdr == OFF_FLAGS_10[WB_ADR_W-1:2])
                      || (wordAdr == OFF_ENABLES_0[WB_ADR_W-1:2]) || (wordAdr == OFF_ENABLES_1[WB_ADR_W-1:2])
                      || (wordAdr == OFF_ENABLES_2[WB_ADR_W-1:2]);

   always_comb begin
      readMux = DAT_ZERO;
      case (wordAdr)
         OFF_FLAGS_9[WB_ADR_W-1:2]: begin
            readMux[REG_W-1:0] = st_r.flags9 & FLAGS_9_MASK;
         end
         OFF_FLAGS_10[WB_ADR_W-1:2]: begin
            readMux[REG_W-1:0] = st_r.flags10 & FLAGS_10_MASK;
         end
         OFF_ENABLES_0[WB_ADR_W-1:2]: begin
            readMux[REG_W-1:0] = st_r.en0;
         end
         OFF_ENABLES_1[WB_ADR_W-1:2]: begin
            readMux[REG_W-1:0] = st_r.en1;
         end
         OFF_ENABLES_2[WB_ADR_W-1:2]: begin
            readMux[REG_W-1:0] = st_r.en2;
         end
         default: begin
            readMux = DAT_ZERO;
         end
      endcase
   end

   always_comb begin
      st_nxt   = st_r;
      f9Write  = st_r.flags9;
      f10Write = st_r.flags10;

      case (st_r.bus)
         BUS_IDLE: begin
            if (busHit) begin
               st_nxt.bus   = BUS_ACK;
               st_nxt.rdata = readMux;
            end
         end
         BUS_ACK: begin
            st_nxt.bus = BUS_IDLE;
         end
         default: begin
            st_nxt.bus = BUS_IDLE;
         end
      endcase

      // Unmapped addresses are acknowledged, read zero and drop writes
      if (wrNow) begin
         case (wordAdr)
            OFF_FLAGS_9[WB_ADR_W-1:2]: begin
               f9Write = wbReq.dat[REG_W-1:0];
            end
            OFF_FLAGS_10[WB_ADR_W-1:2]: begin
               f10Write = wbReq.dat[REG_W-1:0];
            end
            OFF_ENABLES_0[WB_ADR_W-1:2]: begin
               st_nxt.en0 = enables0_s'(wbReq.dat[REG_W-1:0]);
            end
            OFF_ENABLES_1[WB_ADR_W-1:2]: begin
               st_nxt.en1 = enables1_s'(wbReq.dat[REG_W-1:0]);
            end
            OFF_ENABLES_2[WB_ADR_W-1:2]: begin
               st_nxt.en2 = enables2_s'(wbReq.dat[REG_W-1:0]);
            end
            default: begin
               f9Write = st_r.flags9;
            end
         endcase
      end

      // Event set wins over a software clear in the same cycle; only writes clear
      st_nxt.flags9  = (f9Write | {{(REG_W-F9_W){1'b0}}, flags9Event}) & FLAGS_9_MASK;
      st_nxt.flags10 = (f10Write | {{(REG_W-F10_W){1'b0}}, flags10Event}) & FLAGS_10_MASK;

      // Requests follow the next state so they move on the same edge as the bits
      st_nxt.req9  = st_nxt.flags9[F9_W-1:0] & flags9Enable;
      st_nxt.req10 = st_nxt.flags10[F10_W-1:0] & flags10Enable;
      st_nxt.req0  = st_nxt.en0 & en0Flags;
      st_nxt.req1  = st_nxt.en1 & en1Flags;
      st_nxt.req2  = st_nxt.en2 & en2Flags;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wbAck      = st_r.bus[0];
   assign wbDatOut   = st_r.rdata;
   assign flags9Req  = st_r.req9;
   assign flags10Req = st_r.req10;
   assign en0Req     = st_r.req0;
   assign en1Req     = st_r.req1;
   assign en2Req     = st_r.req2;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_request;
      busHit && !wbAck;
   endsequence

   sequence s_answer;
      wbAck ##1 !wbAck;
   endsequence

   property p_one_cycle_answer;
      s_request |=> s_answer;
   endproperty

   AST_ACK_ONE_CYCLE: assert property (p_one_cycle_answer)
      else $error("ack did not follow request by one cycle");

   AST_EVENT_SETS_FLAG9: assert property (
      (flags9Event != 4'h0) |=> ((st_r.flags9[F9_W-1:0] & $past(flags9Event)) == $past(flags9Event)))
      else $error("flag register 9 missed an event");

   AST_FLAG_STICKY: assert property (
      !(wrNow && wordAdr == OFF_FLAGS_10[WB_ADR_W-1:2])
      |=> ((st_r.flags10 & $past(st_r.flags10)) == $past(st_r.flags10)))
      else $error("flag register 10 lost a bit without a write");

   AST_FLAGS9_READ_UPPER_ZERO: assert property (
      (wbAck && wordAdr == OFF_FLAGS_9[WB_ADR_W-1:2]) |-> (wbDatOut[WB_DAT_W-1:F9_W] == 28'h0000000))
      else $error("flag register 9 unimplemented bits read nonzero");

   AST_FLAGS10_READ_UPPER_ZERO: assert property (
      (wbAck && wordAdr == OFF_FLAGS_10[WB_ADR_W-1:2]) |-> (wbDatOut[WB_DAT_W-1:F10_W] == 30'h00000000))
      else $error("flag register 10 unimplemented bits read nonzero");

   sequence s_held_reset;
      !resetn ##1 !resetn;
   endsequence

   // Two low samples are needed: the very first edge may still see power-up unknowns
   AST_RESET_CLEARS: assert property (@(posedge mclk) disable iff (1'b0)
      s_held_reset |-> (st_r.flags9 == REG_RESET && st_r.flags10 == REG_RESET && st_r.en0 == REG_RESET
                   && st_r.en1 == REG_RESET && st_r.en2 == REG_RESET && !wbAck))
      else $error("register not zero during reset");

   AST_SW_WRITE_RAISES_FLAG: assert property (
      (wrNow && wordAdr == OFF_FLAGS_10[WB_ADR_W-1:2] && wbReq.dat[0])
      |=> st_r.flags10.capcomp4_flag)
      else $error("software write of 1 did not raise flag");

   AST_ENABLE1_WRITE: assert property (
      (wrNow && wordAdr == OFF_ENABLES_1[WB_ADR_W-1:2])
      |=> (st_r.en1 == $past(wbReq.dat[REG_W-1:0])))
      else $error("enable register 1 did not take written value");

   AST_ENABLE2_READBACK: assert property (
      (wbAck && wordAdr == OFF_ENABLES_2[WB_ADR_W-1:2] && !$past(wrNow))
      |-> (wbDatOut == {24'h000000, $past(st_r.en2)}))
      else $error("enable register 2 read back wrong");

   AST_REQ_GATE_EN0: assert property (
      en0Req == (st_r.en0 & $past(en0Flags)))
      else $error("enable 0 request not flag and enable");

   AST_REQ_GATE_FLAGS9: assert property (
      flags9Req == (st_r.flags9[F9_W-1:0] & $past(flags9Enable)))
      else $error("flag 9 request not flag and enable");

   AST_REQ_GATE_FLAGS10: assert property (
      flags10Req == (st_r.flags10[F10_W-1:0] & $past(flags10Enable)))
      else $error("flag 10 request not flag and enable");

   AST_REQ_GATE_EN1: assert property (
      en1Req == (st_r.en1 & $past(en1Flags)))
      else $error("enable 1 request not flag and enable");

   AST_REQ_GATE_EN2: assert property (
      en2Req == (st_r.en2 & $past(en2Flags)))
      else $error("enable 2 request not flag and enable");

   AST_EVENT_SETS_FLAG10: assert property (
      (flags10Event != 2'h0) |=> ((st_r.flags10[F10_W-1:0] & $past(flags10Event)) == $past(flags10Event)))
      else $error("flag register 10 missed an event");

   AST_FLAG9_STICKY: assert property (
      !wrFlags9 |=> ((st_r.flags9 & $past(st_r.flags9)) == $past(st_r.flags9)))
      else $error("flag register 9 lost a bit without a write");

   // A write replaces the flags, but an event in the same cycle still sets its bit
   AST_FLAG9_WRITE_VALUE: assert property (
      wrFlags9
      |=> (st_r.flags9 == (($past(wbReq.dat[REG_W-1:0]) | {{(REG_W-F9_W){1'b0}}, $past(flags9Event)})
                           & FLAGS_9_MASK)))
      else $error("flag register 9 did not take the written value");

   AST_FLAG10_WRITE_VALUE: assert property (
      wrFlags10
      |=> (st_r.flags10 == (($past(wbReq.dat[REG_W-1:0]) | {{(REG_W-F10_W){1'b0}}, $past(flags10Event)})
                            & FLAGS_10_MASK)))
      else $error("flag register 10 did not take the written value");

   AST_FLAGS9_UNUSED_ZERO: assert property (
      st_r.flags9.unused9 == '0)
      else $error("flag register 9 stored an unimplemented bit");

   AST_FLAGS10_UNUSED_ZERO: assert property (
      st_r.flags10.unused10 == '0)
      else $error("flag register 10 stored an unimplemented bit");

   AST_ENABLE0_WRITE: assert property (
      wrEn0 |=> (st_r.en0 == $past(wbReq.dat[REG_W-1:0])))
      else $error("enable register 0 did not take written value");

   AST_ENABLE2_WRITE: assert property (
      wrEn2 |=> (st_r.en2 == $past(wbReq.dat[REG_W-1:0])))
      else $error("enable register 2 did not take written value");

   // Enables only ever move on a bus write; hardware never touches them
   AST_ENABLES_HOLD: assert property (
      !(wrEn0 || wrEn1 || wrEn2) |=> ($stable(st_r.en0) && $stable(st_r.en1) && $stable(st_r.en2)))
      else $error("enable register changed without a write");

   // Holes in the map answer zero so a stray read cannot look like a pending flag
   AST_UNMAPPED_READS_ZERO: assert property (
      (wbAck && !mapHit) |-> (wbDatOut == DAT_ZERO))
      else $error("unmapped address read nonzero");

   AST_ACK_NEEDS_REQUEST: assert property (
      wbAck |-> $past(busHit))
      else $error("ack raised without a request");

   AST_ACK_SINGLE_PULSE: assert property (
      wbAck |=> !wbAck)
      else $error("ack stood longer than one cycle");

endmodule

`default_nettype wire

// ==== testbench/irq_source_model.sv ====
/*
 * Stand-in for the peripheral event sources and the interrupt controller side.
 * Assumes the bench calls drive() from its clocked sequence on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module irq_source_model
   import periph_irq_pkg::*;
(
   input  wire logic                mclk,
   output var  logic [F9_W-1:0]     ev9,
   output var  logic [F10_W-1:0]    ev10,
   output var  logic [F9_W-1:0]     en9,
   output var  logic [F10_W-1:0]    en10,
   output var  logic [3*REG_W-1:0]  extFlags
);
   initial begin
      {ev9, ev10, en9, en10, extFlags} = '0;
   end
   // Inputs change just after the edge so the block samples them cleanly
   task automatic drive(input logic [3:0] e9, input logic [1:0] e10, input logic [3:0] n9,
                        input logic [1:0] n10, input logic [23:0] f);
      @(posedge mclk);
      ev9 <= e9;
      ev10 <= e10;
      en9 <= n9;
      en10 <= n10;
      extFlags <= f;
   endtask
endmodule
`default_nettype wire

// ==== testbench/peripheral_irq_flag_enable_regs_tb.sv ====
/*
 * Self-checking bench for the peripheral interrupt flag/enable registers.
 * Assumes the package constants and the one-cycle ack of the Wishbone slave.
 */
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_enable_regs_tb
   import periph_irq_pkg::*;
;
   logic                mclk;
   logic                resetn;
   logic                wbAck;
   wb_req_s             wbReq;
   logic [WB_DAT_W-1:0] wbDatOut;
   logic [WB_DAT_W-1:0] rd;
   logic [WB_SEL_W-1:0] selNow;
   logic [F9_W-1:0]     ev9, en9, req9;
   logic [F10_W-1:0]    ev10, en10, req10;
   logic [3*REG_W-1:0]  extFlags;
   logic [REG_W-1:0]    req0, req1, req2;
   logic [WB_ADR_W-1:0] offs [6];
   int                  miscompares, checkCount;

   irq_source_model src (.mclk(mclk), .ev9(ev9), .ev10(ev10), .en9(en9), .en10(en10), .extFlags(extFlags));
   peripheral_irq_flag_enable_regs dut (.mclk(mclk), .resetn(resetn), .wbReq(wbReq), .wbAck(wbAck),
      .wbDatOut(wbDatOut), .flags9Event(ev9), .flags10Event(ev10), .flags9Enable(en9),
      .flags10Enable(en10), .en0Flags(extFlags[23:16]), .en1Flags(extFlags[15:8]),
      .en2Flags(extFlags[7:0]), .flags9Req(req9), .flags10Req(req10), .en0Req(req0),
      .en1Req(req1), .en2Req(req2));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic results();
      $display("checks %0d miscompares %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Request held until ack is sampled; released only at that edge
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      @(posedge mclk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: selNow, dat: d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         results();
      end
      rd = wbDatOut;
      wbReq <= '0;
   endtask

   task automatic zeroAll();
      foreach (offs[i]) begin
         xfer(1'b0, offs[i], DAT_ZERO);
         check("reset value", rd, 32'h0);
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   initial begin
      wbReq = '0;
      selNow = 4'hf;
      resetn = 1'b0;
      miscompares = 0;
      checkCount = 0;
      offs = '{OFF_FLAGS_9, OFF_FLAGS_10, OFF_ENABLES_0, OFF_ENABLES_1, OFF_ENABLES_2, 8'h40};
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      zeroAll();
      xfer(1'b1, OFF_ENABLES_0, 32'hffff_ff81);
      xfer(1'b1, OFF_ENABLES_1, 32'h0000_003c);
      xfer(1'b1, OFF_ENABLES_2, 32'h0000_00a5);
      xfer(1'b1, 8'h40, 32'h0000_00ff);
      xfer(1'b0, OFF_ENABLES_0, DAT_ZERO);
      check("enables0", rd, 32'h81);
      xfer(1'b0, OFF_ENABLES_1, DAT_ZERO);
      check("enables1", rd, 32'h3c);
      xfer(1'b0, OFF_ENABLES_2, DAT_ZERO);
      check("enables2", rd, 32'ha5);
      selNow = 4'he;
      xfer(1'b1, OFF_ENABLES_0, DAT_ZERO);
      selNow = 4'hf;
      xfer(1'b0, OFF_ENABLES_0, DAT_ZERO);
      check("enables0 low lane off", rd, 32'h81);
      src.drive(4'h0, 2'h0, 4'h0, 2'h0, 24'hf0_0f_c3);
      settle();
      check("en0Req", req0, 8'h80);
      check("en1Req", req1, 8'h0c);
      check("en2Req", req2, 8'h81);
      xfer(1'b1, OFF_FLAGS_9, DAT_ZERO);
      xfer(1'b1, OFF_FLAGS_10, DAT_ZERO);
      src.drive(4'h9, 2'h2, 4'h0, 2'h0, 24'h0);
      src.drive(4'h0, 2'h0, 4'h0, 2'h0, 24'h0);
      settle();
      check("req while disabled", {req9, req10}, 6'h0);
      xfer(1'b0, OFF_FLAGS_9, DAT_ZERO);
      check("flags9", rd, 32'h09);
      xfer(1'b0, OFF_FLAGS_10, DAT_ZERO);
      check("flags10", rd, 32'h02);
      src.drive(4'h1, 2'h0, 4'hb, 2'h3, 24'h0);
      settle();
      check("flags9Req", req9, 4'h9);
      check("flags10Req", req10, 2'h2);
      xfer(1'b1, OFF_FLAGS_9, DAT_ZERO);
      xfer(1'b0, OFF_FLAGS_9, DAT_ZERO);
      check("clear under event", rd, 32'h01);
      src.drive(4'h0, 2'h0, 4'hf, 2'h3, 24'hff_ff_ff);
      settle();
      xfer(1'b0, OFF_FLAGS_9, DAT_ZERO);
      check("flag holds", rd, 32'h01);
      xfer(1'b1, OFF_FLAGS_9, 32'h0000_00f6);
      xfer(1'b0, OFF_FLAGS_9, DAT_ZERO);
      check("flags9 sw set", rd, 32'h06);
      xfer(1'b1, OFF_FLAGS_10, 32'h0000_00fd);
      xfer(1'b0, OFF_FLAGS_10, DAT_ZERO);
      check("flags10 sw set", rd, 32'h01);
      settle();
      check("reqs after set", {req9, req10}, 6'h19);
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      zeroAll();
      check("reqs after reset", {req9, req10, req0}, 14'h0);
      results();
   end
endmodule
`default_nettype wire
